// ### crcfi_pkg.sv
/*
 crc input fifo package: register offsets, field positions, reset values,
 width modes, depths and the carrier structs.
 assumes nothing beyond a SystemVerilog tool.
*/
package crcfi_pkg;
  // byte offsets on the register bus
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_LOW = 4'h8;
  localparam logic [3:0] OFF_HIGH = 4'hC;
  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LSB_BIT = 1;
  localparam int CTRL_DW_POS = 8;
  // status register fields
  localparam int STAT_CNT_POS = 0;
  localparam int STAT_FULL_BIT = 8;
  localparam int STAT_EMPTY_BIT = 9;
  // reset values
  localparam logic EN_RESET = 1'b0;
  localparam logic LSB_RESET = 1'b0;
  localparam logic [4:0] DW_RESET = 5'h00;
  // width field limits and logical depths
  localparam logic [4:0] DW_BYTE_MAX = 5'h07;
  localparam logic [4:0] DW_HALF_MAX = 5'h0F;
  localparam logic [4:0] DW_TOP = 5'h1F;
  localparam logic [4:0] DEPTH_BYTE = 5'h10;
  localparam logic [4:0] DEPTH_HALF = 5'h08;
  localparam logic [4:0] DEPTH_WORD = 5'h04;
  // physical storage
  localparam int STORE_WORDS = 8;
  localparam int STORE_BITS = 16;

  typedef enum logic [1:0] {
    MODE_BYTE = 2'b00,
    MODE_HALF = 2'b01,
    MODE_WORD = 2'b10
  } crcfi_mode_e;

  typedef struct packed {
    logic [4:0] dw;
    logic lsb;
    logic en;
  } crcfi_ctrl_s;

  typedef struct packed {
    logic [31:0] word;
    logic load;
  } crcfi_feed_s;
endpackage : crcfi_pkg

// ### crcfi_fifo.sv
/*
 crc input fifo: avalon-mm register slave, variable width data fifo on
 eight 16-bit storage words, and the word hand-off to the shift engine.
 assumes one 10 MHz clock, a synchronous active-high reset and an engine
 that asks for a word with feed_take and shifts it from bit dw downward.
*/
// Our own choices: the Avalon-MM register port and the placing of the registers.
// Operation
// RULE1 - width field holds width minus one, any width 1 to 32 bits
// RULE2 - widths up to 16 use only the low register; high writes dropped
// RULE3 - software writes the low word before the high word above 16 bits
// RULE4 - software should use byte writes for widths of eight or fewer
// RULE5 - data goes to the engine msb first at 0, lsb first at 1
// RULE6 - direction changes only input bit order, never the checksum order
// RULE7 - storage is eight 16-bit locations holding entries of any width
// RULE8 - five-bit readable count of unconsumed entries
// RULE9 - 16 entries up to width 8, 8 up to 16, 4 above
// RULE10 - reading the low data register returns zero
// RULE11 - byte mode: a write to either low-register byte lane enqueues
// RULE12 - narrow byte modes store whole bytes, feed only the width's bits
// RULE13 - count rises by one when a write covers the width's top bit; a byte-mode write of both low lanes adds two when two entries fit
// RULE14 - 9 to 16 bits: low writes reaching the top bit advance once
// RULE15 - above 16 bits: the high write covering the top bit advances
// RULE16 - writes to either data register are dropped while full
// RULE17 - byte mode word write: low byte first only when lsb first
// RULE18 - half mode: upper lane write advances; later word overrides
// RULE19 - unwritten entry bytes keep stale contents, never cleared; srst here zeroes all eight storage words
// RULE20 - full flag when count reaches the depth of the width
// RULE21 - module disabled: fifo emptied, count held at zero
// RULE22 - count falls by one per consumed entry; empty at zero
// RULE23 - entries leave oldest first with circular pointers
// RULE24 - simultaneous enqueue and dequeue keep the count right
`timescale 1ns/100ps
module crcfi_fifo #(
  parameter int STORE_WORDS = crcfi_pkg::STORE_WORDS,
  parameter int STORE_BITS = crcfi_pkg::STORE_BITS
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic feed_take,
  output crcfi_pkg::crcfi_feed_s feed,
  output crcfi_pkg::crcfi_ctrl_s ctrl,
  output logic [4:0] valid_entry_count,
  output logic fifo_full_flag,
  output logic fifo_empty_flag
);
  if (STORE_WORDS != 8 || STORE_BITS != 16) begin : g_chk
    $error("crcfi_fifo serves only eight 16-bit storage words");
  end

  function automatic crcfi_pkg::crcfi_mode_e mode_of(input logic [4:0] dw);
    if (dw <= crcfi_pkg::DW_BYTE_MAX) begin
      mode_of = crcfi_pkg::MODE_BYTE;
    end else if (dw <= crcfi_pkg::DW_HALF_MAX) begin
      mode_of = crcfi_pkg::MODE_HALF;
    end else begin
      mode_of = crcfi_pkg::MODE_WORD;
    end
  endfunction : mode_of

  function automatic logic [4:0] depth_of(input crcfi_pkg::crcfi_mode_e m);
    case (m)
      crcfi_pkg::MODE_BYTE: depth_of = crcfi_pkg::DEPTH_BYTE;
      crcfi_pkg::MODE_HALF: depth_of = crcfi_pkg::DEPTH_HALF;
      default: depth_of = crcfi_pkg::DEPTH_WORD;
    endcase
  endfunction : depth_of

  // circular advance of an entry pointer within the logical depth
  function automatic logic [3:0] adv(input logic [3:0] p, input logic [4:0] d);
    logic [4:0] n;
    n = {1'b0, p} + 5'h01;
    adv = (n == d) ? 4'h0 : n[3:0];
  endfunction : adv

  logic [STORE_BITS-1:0] mem [STORE_WORDS];
  logic [3:0] wp;
  logic [3:0] rp;
  logic [3:0] wp_nxt;
  logic ack;
  crcfi_pkg::crcfi_mode_e mode;
  logic [4:0] depth;
  logic wr_acc, rd_req, wr_lo, wr_hi, hi_drop, pop, space2;
  logic [1:0] push;
  logic [7:0] fst, snd;
  logic [4:0] next_count;
  logic [31:0] head, masked, rev;

  assign mode = mode_of(ctrl.dw); // RULE1
  assign depth = depth_of(mode); // RULE9
  // one shared next slot keeps the second byte index at storage width
  assign wp_nxt = adv(wp, depth);

  // one wait cycle per access gives registered read data
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_acc = avs_write & ack;
  assign rd_req = avs_read & ~ack;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl.en <= crcfi_pkg::EN_RESET;
      ctrl.lsb <= crcfi_pkg::LSB_RESET; // RULE5
      ctrl.dw <= crcfi_pkg::DW_RESET;
    end else if (wr_acc && avs_address == crcfi_pkg::OFF_CTRL) begin
      if (avs_byteenable[0]) begin
        ctrl.en <= avs_writedata[crcfi_pkg::CTRL_EN_BIT];
        ctrl.lsb <= avs_writedata[crcfi_pkg::CTRL_LSB_BIT];
      end
      if (avs_byteenable[1]) begin
        ctrl.dw <= avs_writedata[crcfi_pkg::CTRL_DW_POS +: 5]; // RULE1
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_req) begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        crcfi_pkg::OFF_CTRL: begin
          avs_readdata[crcfi_pkg::CTRL_EN_BIT] <= ctrl.en;
          avs_readdata[crcfi_pkg::CTRL_LSB_BIT] <= ctrl.lsb;
          avs_readdata[crcfi_pkg::CTRL_DW_POS +: 5] <= ctrl.dw;
        end
        crcfi_pkg::OFF_STAT: begin
          avs_readdata[crcfi_pkg::STAT_CNT_POS +: 5] <= valid_entry_count; // RULE8
          avs_readdata[crcfi_pkg::STAT_FULL_BIT] <= fifo_full_flag;
          avs_readdata[crcfi_pkg::STAT_EMPTY_BIT] <= fifo_empty_flag;
        end
        // data registers and holes read as zero
        default: avs_readdata <= 32'h0000_0000; // RULE10
      endcase
    end
  end

  // accepted data writes; full or disabled drops them silently
  always_comb begin
    wr_lo = wr_acc && avs_address == crcfi_pkg::OFF_LOW && ctrl.en && !fifo_full_flag; // RULE16
    hi_drop = mode != crcfi_pkg::MODE_WORD; // RULE2
    wr_hi = wr_acc && avs_address == crcfi_pkg::OFF_HIGH && ctrl.en && !fifo_full_flag && !hi_drop;
    space2 = (valid_entry_count + 5'h02) <= depth;
    if (avs_byteenable[1:0] == 2'b11) begin
      fst = ctrl.lsb ? avs_writedata[7:0] : avs_writedata[15:8]; // RULE17
    end else begin
      fst = avs_byteenable[0] ? avs_writedata[7:0] : avs_writedata[15:8];
    end
    snd = ctrl.lsb ? avs_writedata[15:8] : avs_writedata[7:0];
    push = 2'b00;
    case (mode)
      crcfi_pkg::MODE_BYTE: begin
        if (wr_lo && avs_byteenable[1:0] != 2'b00) begin // RULE11
          push = (avs_byteenable[1:0] == 2'b11 && space2) ? 2'b10 : 2'b01; // RULE13
        end
      end
      crcfi_pkg::MODE_HALF: begin
        if (wr_lo && avs_byteenable[1]) begin // RULE14
          push = 2'b01;
        end
      end
      crcfi_pkg::MODE_WORD: begin
        if (wr_hi && avs_byteenable[{1'b0, ctrl.dw[3]}]) begin // RULE15
          push = 2'b01;
        end
      end
      default: push = 2'b00;
    endcase
  end

  // storage holds no clear on disable, so skipped bytes stay stale
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < STORE_WORDS; i++) begin
        mem[i] <= '0;
      end
    end else begin
      case (mode)
        crcfi_pkg::MODE_BYTE: begin
          if (push != 2'b00) begin
            mem[wp[3:1]][{wp[0], 3'h0} +: 8] <= fst; // RULE7
          end
          if (push == 2'b10) begin
            mem[wp_nxt[3:1]][{wp_nxt[0], 3'h0} +: 8] <= snd;
          end
        end
        crcfi_pkg::MODE_HALF: begin
          if (wr_lo && avs_byteenable[0]) begin
            mem[wp[2:0]][7:0] <= avs_writedata[7:0]; // RULE18
          end
          if (wr_lo && avs_byteenable[1]) begin
            mem[wp[2:0]][15:8] <= avs_writedata[15:8];
          end
        end
        crcfi_pkg::MODE_WORD: begin
          if ((wr_lo || wr_hi) && avs_byteenable[0]) begin
            mem[{wp[1:0], wr_hi}][7:0] <= avs_writedata[7:0];
          end
          if ((wr_lo || wr_hi) && avs_byteenable[1]) begin
            mem[{wp[1:0], wr_hi}][15:8] <= avs_writedata[15:8]; // RULE19
          end
        end
        default: ;
      endcase
    end
  end

  assign pop = feed_take && valid_entry_count != 5'h00;
  assign next_count = valid_entry_count + {3'h0, push} - {4'h0, pop}; // RULE24

  always_ff @(posedge mclk) begin
    if (srst || !ctrl.en) begin
      valid_entry_count <= 5'h00; // RULE21
      fifo_full_flag <= 1'b0;
      fifo_empty_flag <= 1'b1;
      wp <= 4'h0;
      rp <= 4'h0;
    end else begin
      valid_entry_count <= next_count; // RULE22
      fifo_full_flag <= next_count == depth; // RULE20
      fifo_empty_flag <= next_count == 5'h00;
      if (push == 2'b10) begin
        wp <= adv(wp_nxt, depth);
      end else if (push == 2'b01) begin
        wp <= wp_nxt;
      end
      if (pop) begin
        rp <= adv(rp, depth); // RULE23
      end
    end
  end

  // oldest entry, cut to the width; lsb first mirrors it within the width
  always_comb begin
    case (mode)
      crcfi_pkg::MODE_BYTE: head = {24'h000000, mem[rp[3:1]][{rp[0], 3'h0} +: 8]};
      crcfi_pkg::MODE_HALF: head = {16'h0000, mem[rp[2:0]]};
      default: head = {mem[{rp[1:0], 1'b1}], mem[{rp[1:0], 1'b0}]};
    endcase
    masked = head & (32'hFFFF_FFFF >> (crcfi_pkg::DW_TOP - ctrl.dw)); // RULE12
    for (int i = 0; i < 32; i++) begin
      rev[i] = masked[31 - i];
    end
  end

  // only the feed order flips; the engine's remainder is left untouched
  always_ff @(posedge mclk) begin
    if (srst) begin
      feed <= '0;
    end else begin
      feed.load <= pop;
      if (pop) begin
        feed.word <= ctrl.lsb ? (rev >> (crcfi_pkg::DW_TOP - ctrl.dw)) : masked; // RULE5 RULE6
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_low_read;
    avs_read && !ack && avs_address == crcfi_pkg::OFF_LOW ##1 avs_read && ack;
  endsequence
  sequence s_byte_single;
    ctrl.en && mode == crcfi_pkg::MODE_BYTE && !fifo_full_flag && !pop && wr_acc
      && avs_address == crcfi_pkg::OFF_LOW && (avs_byteenable[0] ^ avs_byteenable[1]);
  endsequence
  sequence s_half_low_only;
    ctrl.en && mode == crcfi_pkg::MODE_HALF && !pop && wr_acc
      && avs_address == crcfi_pkg::OFF_LOW && avs_byteenable[1:0] == 2'b01;
  endsequence

  low_read_zero_a: assert property (s_low_read |-> avs_readdata == 32'h0000_0000) // RULE10
    else $error("low data register read not zero");
  count_bound_a: assert property ($stable(ctrl.dw) |-> valid_entry_count <= depth) // RULE9
    else $error("entry count above depth");
  full_flag_a: assert property ($stable(ctrl) && ctrl.en |=> fifo_full_flag == (valid_entry_count == depth)) // RULE20
    else $error("full flag disagrees with count");
  disable_clear_a: assert property (!ctrl.en |=> valid_entry_count == 5'h00 && fifo_empty_flag) // RULE21
    else $error("disabled fifo not empty");
  pop_dec_a: assert property (ctrl.en && pop && push == 2'b00 |=> // RULE22
    valid_entry_count == $past(valid_entry_count) - 5'h01)
    else $error("dequeue did not decrement");
  push_pop_a: assert property (ctrl.en && pop && push == 2'b01 |=> $stable(valid_entry_count)) // RULE24
    else $error("count moved on push with pop");
  high_drop_a: assert property (wr_acc && avs_address == crcfi_pkg::OFF_HIGH && hi_drop |-> push == 2'b00) // RULE2
    else $error("high write enqueued in narrow mode");
  full_drop_a: assert property (fifo_full_flag && !pop |=> valid_entry_count <= $past(valid_entry_count)) // RULE16
    else $error("write accepted while full");
  byte_push_a: assert property (s_byte_single |=> valid_entry_count == $past(valid_entry_count) + 5'h01) // RULE11
    else $error("byte write did not enqueue");
  half_hold_a: assert property (s_half_low_only |=> $stable(valid_entry_count)) // RULE18
    else $error("lower lane write advanced fifo");
  feed_load_a: assert property (pop && !ctrl.lsb |=> feed.load && feed.word == $past(masked)) // RULE12
    else $error("fed word wrong");
endmodule : crcfi_fifo

// ### crcfi_engine_model.sv
/*
 shift engine stand-in: asks for entries while allowed and keeps each
 delivered word in a queue for the bench.
 assumes the feed struct of crcfi_pkg and the mclk domain.
*/
`timescale 1ns/100ps
module crcfi_engine_model (
  input wire logic mclk,
  input wire logic take_en,
  input wire crcfi_pkg::crcfi_feed_s feed,
  output logic feed_take
);
  logic [31:0] got_q[$];
  // a stalled engine simply stops asking; the fifo must hold its entries
  assign feed_take = take_en;
  always @(posedge mclk) begin
    if (feed.load === 1'b1) begin
      got_q.push_back(feed.word);
    end
  end
endmodule : crcfi_engine_model

// ### testbench.sv
/*
 crc input fifo bench: avalon-mm register tasks, fifo fill and drain
 sequences in byte, half and word modes.
 assumes crcfi_fifo, crcfi_engine_model and crcfi_pkg are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic feed_take;
  logic take_en = 1'b0;
  crcfi_pkg::crcfi_feed_s feed;
  crcfi_pkg::crcfi_ctrl_s ctrl;
  logic [4:0] cnt;
  logic full;
  logic empty;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int check_count = 0;
  always #50 mclk = ~mclk;
  crcfi_fifo dut_u (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .feed_take(feed_take),
    .feed(feed), .ctrl(ctrl), .valid_entry_count(cnt), .fifo_full_flag(full), .fifo_empty_flag(empty));
  crcfi_engine_model eng_u (.mclk(mclk), .take_en(take_en), .feed(feed), .feed_take(feed_take));
  task test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // holds the request until waitrequest is sampled low at a rising edge
  task bus(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= rd;
    avs_write <= ~rd;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("Error bus answer expected 0 seen 1");
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b0, a, d, be, q);
  endtask : wr
  task rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, 4'hF, q);
    chk(name, q, exp);
  endtask : rd_chk
  task drain();
    take_en <= 1'b1;
    repeat (40) @(posedge mclk);
    take_en <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("pops", 32'(eng_u.got_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && eng_u.got_q.size() > 0) begin
      chk("feed", eng_u.got_q.pop_front(), exp_q.pop_front());
    end
    eng_u.got_q.delete();
    exp_q.delete();
  endtask : drain
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd_chk("ctrl", crcfi_pkg::OFF_CTRL, 32'h0);
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h200);
    rd_chk("low", crcfi_pkg::OFF_LOW, 32'h0);
    rd_chk("unmapped", 4'h2, 32'h0);
    // byte mode, msb first: word write sends high byte first
    wr(crcfi_pkg::OFF_CTRL, 32'h0701, 4'h3);
    rd_chk("ctrl", crcfi_pkg::OFF_CTRL, 32'h0701);
    chk("ctrl pin", 32'(ctrl), 32'h1D);
    wr(crcfi_pkg::OFF_LOW, 32'h0C03, 4'h3);
    wr(crcfi_pkg::OFF_LOW, 32'h0B00, 4'h2);
    wr(crcfi_pkg::OFF_LOW, 32'h0001, 4'h1);
    rd_chk("low", crcfi_pkg::OFF_LOW, 32'h0);
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h004);
    exp_q = '{32'h0C, 32'h03, 32'h0B, 32'h01};
    drain();
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h200);
    // lsb first: low byte first, bits reversed within the width
    wr(crcfi_pkg::OFF_CTRL, 32'h0703, 4'h3);
    wr(crcfi_pkg::OFF_LOW, 32'h0C03, 4'h3);
    exp_q = '{32'hC0, 32'h30};
    drain();
    // six-bit width ignores the two top bits of each byte
    wr(crcfi_pkg::OFF_CTRL, 32'h0501, 4'h3);
    wr(crcfi_pkg::OFF_LOW, 32'h00FF, 4'h1);
    exp_q = '{32'h3F};
    drain();
    // byte depth: seventeenth write refused while full
    wr(crcfi_pkg::OFF_CTRL, 32'h0701, 4'h3);
    for (int i = 0; i < 17; i++) begin
      wr(crcfi_pkg::OFF_LOW, 32'(i), 4'h1);
      if (i < 16) begin
        exp_q.push_back(32'(i));
      end
    end
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h110);
    chk("count pin", 32'(cnt), 32'h10);
    chk("full pin", 32'(full), 32'h1);
    drain();
    // half mode: high register dropped, upper lane advances
    wr(crcfi_pkg::OFF_CTRL, 32'h0F01, 4'h3);
    wr(crcfi_pkg::OFF_HIGH, 32'h1234, 4'h3);
    wr(crcfi_pkg::OFF_LOW, 32'h0002, 4'h1);
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h200);
    wr(crcfi_pkg::OFF_LOW, 32'h0B00, 4'h2);
    wr(crcfi_pkg::OFF_LOW, 32'h0A01, 4'h3);
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h002);
    exp_q = '{32'h0B02, 32'h0A01};
    drain();
    // engine keeps taking while a new entry lands
    for (int i = 0; i < 6; i++) begin
      wr(crcfi_pkg::OFF_LOW, 32'h0100 + 32'(i), 4'h3);
      exp_q.push_back(32'h0100 + 32'(i));
    end
    take_en <= 1'b1;
    wr(crcfi_pkg::OFF_LOW, 32'h0200, 4'h3);
    exp_q.push_back(32'h0200);
    drain();
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h200);
    // 24-bit width: high lane 0 holds the top bit
    wr(crcfi_pkg::OFF_CTRL, 32'h1701, 4'h3);
    wr(crcfi_pkg::OFF_LOW, 32'h0E05, 4'h3);
    wr(crcfi_pkg::OFF_HIGH, 32'h0F06, 4'h1);
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h001);
    exp_q = '{32'h060E05};
    drain();
    for (int i = 0; i < 5; i++) begin
      wr(crcfi_pkg::OFF_LOW, 32'h1111, 4'h3);
      wr(crcfi_pkg::OFF_HIGH, 32'(i), 4'h1);
    end
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h104);
    // disable empties the fifo
    wr(crcfi_pkg::OFF_CTRL, 32'h1700, 4'h3);
    rd_chk("status", crcfi_pkg::OFF_STAT, 32'h200);
    chk("count pin", 32'(cnt), 32'h0);
    chk("empty pin", 32'(empty), 32'h1);
    test_done();
  end
endmodule : testbench
